/* File: core/sdl_input_latch.sv */
// serial input front end and converter latch of a 16-bit converter
// assumes mclk well above the bit clock rate; cs_n, sclk, serial_data_in and
// force_midscale_n arrive asynchronously and pass two flip-flops before use
//
// Contract
// R1: latch code is twos complement, 8000 most negative
// R2: chip select falling starts transfer, count cleared
// R3: shift data on bit-clock rise, MSB first
// R4: latch loads on fall after 16th rise
// R5: further bit-clock edges ignored after update
// R6: new sequence only at next chip-select fall
// R7: early chip-select rise discards partial word
// R8: chip select high ignores clock and data
// R9: force low at 16th cycle loads midcode
// R10: force high at 16th cycle loads word
// R11: force acts only at 16th falling edge
// R12: force never disturbs shifting or shifted bits
// R13: host bit clock at most 50 MHz
// R14: reset gives midcode latch and idle receiver
`timescale 1ns/1ps
`default_nettype none
`include "sdl_regs.svh"

module sdl_input_latch (
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire logic                   cs_n,
   input  wire logic                   sclk,
   input  wire logic                   serial_data_in,
   input  wire logic                   force_midscale_n,
   input  wire logic                   latch_accept,
   output var  logic [`SDL_WORD_W-1:0] latch_code,
   output var  logic [`SDL_WORD_W-1:0] string_tap,
   output var  logic                   latch_strobe,
   output var  logic                   word_ready,
   output var  logic                   overrun,
   output var  logic                   receiving
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   localparam logic [`SDL_PIN_COUNT-1:0] PIN_RST = `SDL_PINS_IDLE;

   logic cs_s;
   logic sclk_s;
   logic data_s;
   logic force_s;

   // equal latency on every pin keeps data aligned to its clock edge
   sdl_sync #(
      .RESET_VAL (PIN_RST[`SDL_PIN_CS])
   ) u_sync_cs (
      .mclk  (mclk),
      .rst   (rst),
      .pin   (cs_n),
      .level (cs_s)
   );

   sdl_sync #(
      .RESET_VAL (PIN_RST[`SDL_PIN_SCLK])
   ) u_sync_sclk (
      .mclk  (mclk),
      .rst   (rst),
      .pin   (sclk),
      .level (sclk_s)
   );

   sdl_sync #(
      .RESET_VAL (PIN_RST[`SDL_PIN_DATA])
   ) u_sync_data (
      .mclk  (mclk),
      .rst   (rst),
      .pin   (serial_data_in),
      .level (data_s)
   );

   // force goes through the same two stages so that it lines up with
   // the bit clock edge at which it is judged
   sdl_sync #(
      .RESET_VAL (PIN_RST[`SDL_PIN_FORCE])
   ) u_sync_force (
      .mclk  (mclk),
      .rst   (rst),
      .pin   (force_midscale_n),
      .level (force_s)
   );

   // ------------------------------------------------------------
   // edge detection on synchronised levels
   // ------------------------------------------------------------
   logic cs_d;
   logic sclk_d;

   // delayed copies reset to the idle pin levels, so no false edge
   // is seen when reset lets go
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cs_d <= 1'b1;
      end else begin
         cs_d <= cs_s;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sclk_d <= 1'b0;
      end else begin
         sclk_d <= sclk_s;
      end
   end

   wire cs_fall   = cs_d && !cs_s;
   wire cs_rise   = !cs_d && cs_s;
   // bit clock edges count only while selected
   wire sclk_rise = !sclk_d && sclk_s && !cs_s; // R8
   wire sclk_fall = sclk_d && !sclk_s && !cs_s; // R8

   // ------------------------------------------------------------
   // receive state machine
   // ------------------------------------------------------------
   sdl_pkg::sdl_state_t       state;
   sdl_pkg::sdl_state_t       next_state;
   logic [`SDL_CNT_W-1:0]     bit_cnt;
   logic [`SDL_CNT_W-1:0]     next_bit_cnt;
   sdl_pkg::sdl_word_t        shreg;
   sdl_pkg::sdl_word_t        next_shreg;

   wire in_shift = (state == sdl_pkg::SDL_SHIFT);
   wire is_full  = (bit_cnt == `SDL_FULL_COUNT);
   wire do_shift = in_shift && sclk_rise && !is_full; // R3
   wire do_load  = in_shift && sclk_fall && is_full;  // R4

   // force is looked at only on the loading edge
   wire sdl_pkg::sdl_word_t load_word =
      force_s ? shreg : `SDL_MIDCODE; // R9 R10 R11

   always_comb begin
      next_state   = state;
      next_bit_cnt = bit_cnt;
      next_shreg   = shreg;
      unique case (state)
         sdl_pkg::SDL_IDLE: begin
            if (cs_fall) begin
               next_state   = sdl_pkg::SDL_SHIFT; // R2 R6
               next_bit_cnt = `SDL_CNT_ZERO;      // R2
            end
         end
         sdl_pkg::SDL_SHIFT: begin
            if (cs_rise) begin
               // partial word dropped, latch untouched
               next_state = sdl_pkg::SDL_IDLE; // R7
            end else if (do_load) begin
               next_state = sdl_pkg::SDL_DONE; // R4
            end else if (do_shift) begin
               // force is not consulted here
               next_shreg   = {shreg[`SDL_WORD_W-2:0], data_s}; // R3 R12
               next_bit_cnt = bit_cnt + `SDL_CNT_ONE;
            end
         end
         sdl_pkg::SDL_DONE: begin
            // clocking ignored until chip select cycles
            if (cs_rise) begin
               next_state = sdl_pkg::SDL_IDLE; // R5 R6
            end
         end
         default: begin
            next_state = sdl_pkg::SDL_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= sdl_pkg::SDL_IDLE; // R14
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bit_cnt <= `SDL_CNT_ZERO;
      end else begin
         bit_cnt <= next_bit_cnt;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         shreg <= `SDL_MIDCODE;
      end else begin
         shreg <= next_shreg;
      end
   end

   // ------------------------------------------------------------
   // word fifo between receiver and converter latch
   // ------------------------------------------------------------
   sdl_stream_if #(.W(`SDL_WORD_W)) strm ();

   // a full fifo cannot stall the host, so the word is dropped
   // and overrun is raised instead
   assign strm.wvalid = do_load;
   assign strm.wdata  = load_word;

   sdl_fifo #(
      .W     (`SDL_WORD_W),
      .DEPTH (`SDL_FIFO_DEPTH)
   ) u_fifo (
      .mclk (mclk),
      .rst  (rst),
      .s    (strm.store)
   );

   assign strm.rready = latch_accept;
   wire do_latch = strm.rvalid && latch_accept;

   // ------------------------------------------------------------
   // converter latch and status outputs
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         latch_code <= `SDL_MIDCODE; // R14
      end else if (do_latch) begin
         latch_code <= strm.rdata;
      end
   end

   // offset binary tap: 0000 bottom, 8000 middle, FFFF top
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         string_tap <= `SDL_SIGN_FLIP; // R1 R14
      end else if (do_latch) begin
         string_tap <= strm.rdata ^ `SDL_SIGN_FLIP; // R1
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         latch_strobe <= 1'b0;
      end else begin
         latch_strobe <= do_latch;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         word_ready <= 1'b1;
      end else begin
         word_ready <= strm.wready;
      end
   end

   // sticky: only reset clears it, so a lost word is never hidden
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         overrun <= 1'b0;
      end else if (do_load && !strm.wready) begin
         overrun <= 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         receiving <= 1'b0;
      end else begin
         receiving <= (next_state == sdl_pkg::SDL_SHIFT);
      end
   end

endmodule : sdl_input_latch

`default_nettype wire

/* File: core/sdl_regs.svh */
// constants of the serial converter input latch
// assumes inclusion by bare name from core/ and tb/ files
`ifndef SDL_REGS_SVH
`define SDL_REGS_SVH

`define SDL_WORD_W        16
`define SDL_CNT_W         5
`define SDL_FULL_COUNT    5'h10
`define SDL_CNT_ZERO      5'h00
`define SDL_CNT_ONE       5'h01
`define SDL_MIDCODE       16'h0000
`define SDL_SIGN_FLIP     16'h8000
`define SDL_FIFO_DEPTH    8
`define SDL_SYNC_STAGES   2
`define SDL_PIN_COUNT     4
`define SDL_PIN_CS        0
`define SDL_PIN_SCLK      1
`define SDL_PIN_DATA      2
`define SDL_PIN_FORCE     3
`define SDL_PINS_IDLE     4'h9

`endif

/* File: core/sdl_pkg.sv */
// types of the serial converter input latch
// assumes sdl_regs.svh for the word width; the state codes are written here
`include "sdl_regs.svh"

package sdl_pkg;

   typedef logic [`SDL_WORD_W-1:0] sdl_word_t;

   // receive states, one-hot
   typedef enum logic [2:0] {
      SDL_IDLE  = 3'h1,
      SDL_SHIFT = 3'h2,
      SDL_DONE  = 3'h4
   } sdl_state_t;

endpackage : sdl_pkg

/* File: core/sdl_stream_if.sv */
// valid/ready stream between the receiver, the word fifo and the latch
// assumes one clock, mclk, on both sides
`timescale 1ns/1ps
`default_nettype none

interface sdl_stream_if #(
   parameter int W = 16
);
   logic [W-1:0] wdata;
   logic         wvalid;
   logic         wready;
   logic [W-1:0] rdata;
   logic         rvalid;
   logic         rready;

   modport fill  (output wdata, output wvalid, input wready);
   modport store (input wdata, input wvalid, output wready,
                  output rdata, output rvalid, input rready);
   modport drain (input rdata, input rvalid, output rready);
endinterface : sdl_stream_if

`default_nettype wire

/* File: core/sdl_sync.sv */
// two-stage synchroniser for one pin from outside the mclk domain
// assumes the pin level is stable for at least two mclk periods
`timescale 1ns/1ps
`default_nettype none

module sdl_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic pin,
   output var  logic level
);
   logic meta;

   // meta is read only by level
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta  <= RESET_VAL;
         level <= RESET_VAL;
      end else begin
         meta  <= pin;
         level <= meta;
      end
   end
endmodule : sdl_sync

`default_nettype wire

/* File: core/sdl_fifo.sv */
// word fifo, flip-flop storage addressed by index
// assumes the filler pulses wvalid for one cycle and drops the word if wready is low
`timescale 1ns/1ps
`default_nettype none

module sdl_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 8
) (
   input  wire logic    mclk,
   input  wire logic    rst,
   sdl_stream_if.store  s
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] LAST  = AW'(DEPTH - 1);
   localparam logic [CW-1:0] FULLC = CW'(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_idx;
   logic [AW-1:0] rd_idx;
   logic [CW-1:0] count;

   wire do_push = s.wvalid && s.wready;
   wire do_pop  = s.rvalid && s.rready;

   assign s.wready = (count != FULLC);
   assign s.rvalid = (count != '0);
   assign s.rdata  = mem[rd_idx];

   always_ff @(posedge mclk) begin
      if (do_push) begin
         mem[wr_idx] <= s.wdata;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_idx <= '0;
         rd_idx <= '0;
         count  <= '0;
      end else begin
         if (do_push) begin
            wr_idx <= (wr_idx == LAST) ? '0 : wr_idx + 1'b1;
         end
         if (do_pop) begin
            rd_idx <= (rd_idx == LAST) ? '0 : rd_idx + 1'b1;
         end
         if (do_push && !do_pop) begin
            count <= count + 1'b1;
         end else if (do_pop && !do_push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule : sdl_fifo

`default_nettype wire

/* File: tb/sdl_asserts.sv */
// concurrent checks on the input latch ports
// assumes raw pins; the design sees them two mclk late
`timescale 1ns/1ps
`default_nettype none
`include "sdl_regs.svh"
module sdl_asserts (
   input wire logic                   mclk,
   input wire logic                   rst,
   input wire logic                   cs_n,
   input wire logic                   sclk,
   input wire logic                   serial_data_in,
   input wire logic                   force_midscale_n,
   input wire logic                   latch_accept,
   input wire logic [`SDL_WORD_W-1:0] latch_code,
   input wire logic [`SDL_WORD_W-1:0] string_tap,
   input wire logic                   latch_strobe,
   input wire logic                   word_ready,
   input wire logic                   overrun,
   input wire logic                   receiving
);
   // ---
   // pin-side rise count
   // ---
   logic [4:0] rise_cnt;
   logic       sclk_q;
   wire        fall16;
   assign fall16 = !cs_n && sclk_q && !sclk && rise_cnt == 5'h10;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rise_cnt <= 5'h00;
         sclk_q   <= 1'b0;
      end else begin
         sclk_q <= sclk;
         // saturates past 16 so later falls are not taken for the 16th
         if (cs_n)
            rise_cnt <= 5'h00;
         else if (!sclk_q && sclk && rise_cnt != 5'h1F)
            rise_cnt <= rise_cnt + 5'h01;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_load;
      ##[3:6] latch_strobe;
   endsequence
   sequence s_mid;
      ##[3:6] (latch_strobe && latch_code == 16'h0000);
   endsequence
   a_tap_offset: assert property (string_tap == (latch_code ^ 16'h8000))
      else $error("tap not offset view of latch");
   a_code_strobed: assert property ($changed(latch_code) |-> latch_strobe)
      else $error("latch changed without strobe");
   a_start_rx: assert property ($fell(cs_n) |-> ##[2:5] receiving)
      else $error("no receive after select");
   a_idle_quiet: assert property (cs_n [*6] |-> !receiving)
      else $error("receiving while deselected");
   a_load_word: assert property
      (fall16 && force_midscale_n && latch_accept |-> s_load)
      else $error("no strobe after last fall");
   a_load_mid: assert property
      (fall16 && !force_midscale_n && latch_accept |-> s_mid)
      else $error("midcode not loaded");
   a_partial_drop: assert property ($rose(cs_n) && rise_cnt < 5'h10
      && latch_accept |-> ##1 (!latch_strobe) [*6])
      else $error("partial word loaded");
   a_overrun_held: assert property (overrun |=> overrun)
      else $error("overrun cleared");
endmodule : sdl_asserts
bind sdl_input_latch sdl_asserts i_sdl_asserts (
   .mclk(mclk), .rst(rst), .cs_n(cs_n), .sclk(sclk),
   .serial_data_in(serial_data_in), .force_midscale_n(force_midscale_n),
   .latch_accept(latch_accept), .latch_code(latch_code),
   .string_tap(string_tap), .latch_strobe(latch_strobe),
   .word_ready(word_ready), .overrun(overrun), .receiving(receiving));
`default_nettype wire

/* File: tb/sdl_host_model.sv */
// host serial master driving the converter pins
// assumes mclk at 100 MHz; bit clock 80 ns period
`timescale 1ns/1ps
`default_nettype none
module sdl_host_model (
   input  wire logic mclk,
   output var  logic cs_n,
   output var  logic sclk,
   output var  logic serial_data_in
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      serial_data_in = 1'b1;
   end
   // n rises; bits past 16 and idle data toggle so no stale level shows
   task automatic xfer(input logic [15:0] w, input int n);
      @(posedge mclk) cs_n <= 1'b0;
      repeat (4) @(posedge mclk);
      for (int i = 0; i < n; i++) begin
         serial_data_in <= (i < 16) ? w[15-i] : ~serial_data_in;
         repeat (4) @(posedge mclk);
         sclk <= 1'b1;
         repeat (4) @(posedge mclk);
         sclk <= 1'b0;
      end
      repeat (16) @(posedge mclk);
      cs_n <= 1'b1;
      serial_data_in <= ~serial_data_in;
      repeat (8) @(posedge mclk);
   endtask : xfer
endmodule : sdl_host_model
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the converter input latch
// assumes the host model drives the serial pins
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        force_n = 1'b1;
   logic        accept = 1'b1;
   logic        cs_n, sclk, serial_data_in;
   logic [15:0] latch_code, string_tap;
   logic        latch_strobe, word_ready, overrun, receiving;
   int          fail_count = 0;
   int          compares = 0;
   int          cycles = 0;
   always #5 mclk = ~mclk;
   sdl_host_model i_sdl_host_model (.mclk(mclk), .cs_n(cs_n),
      .sclk(sclk), .serial_data_in(serial_data_in));
   sdl_input_latch i_sdl_input_latch (.mclk(mclk), .rst(rst),
      .cs_n(cs_n), .sclk(sclk), .serial_data_in(serial_data_in),
      .force_midscale_n(force_n), .latch_accept(accept),
      .latch_code(latch_code), .string_tap(string_tap),
      .latch_strobe(latch_strobe), .word_ready(word_ready),
      .overrun(overrun), .receiving(receiving));
   task automatic stop_test;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test
   task automatic chk16(string what, logic [15:0] e, logic [15:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : chk16
   task automatic chk1(string what, logic e, logic g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %b seen %b", what, e, g);
      end
   endtask : chk1
   task automatic send(logic [15:0] w, int n, logic [15:0] e);
      i_sdl_host_model.xfer(w, n);
      #1;
      chk16("latch_code", e, latch_code);
      chk16("string_tap", e ^ 16'h8000, string_tap);
   endtask : send
   task automatic t_codes;
      logic [15:0] tbl [6] = '{16'h7FFF, 16'h0000, 16'h8000,
                               16'h4FFF, 16'hBFFF, 16'hA5C3};
      foreach (tbl[k])
         send(tbl[k], 16, tbl[k]);
   endtask : t_codes
   task automatic t_frames;
      send(16'h1234, 16, 16'h1234);
      send(16'hFFFF, 10, 16'h1234);
      send(16'h0F0F, 16, 16'h0F0F);
      send(16'h2222, 18, 16'h2222);
   endtask : t_frames
   task automatic t_force;
      @(posedge mclk);
      force_n <= 1'b0;
      send(16'h5555, 16, 16'h0000);
      @(posedge mclk);
      force_n <= 1'b1;
      repeat (20) @(posedge mclk);
      #1;
      chk16("held_mid", 16'h0000, latch_code);
      fork
         send(16'h3C3C, 16, 16'h3C3C);
         begin
            repeat (20) @(posedge mclk);
            force_n <= 1'b0;
            repeat (40) @(posedge mclk);
            force_n <= 1'b1;
            repeat (20) @(posedge mclk);
            #1;
            chk16("mid_held", 16'h0000, latch_code);
         end
      join
   endtask : t_force
   task automatic t_buffer;
      int k;
      @(posedge mclk);
      accept <= 1'b0;
      for (k = 0; k < 9; k++)
         i_sdl_host_model.xfer(16'h1000 + 16'(k), 16);
      #1;
      chk1("word_ready", 1'b0, word_ready);
      chk1("overrun", 1'b1, overrun);
      chk16("latch_code", 16'h3C3C, latch_code);
      @(posedge mclk);
      accept <= 1'b1;
      k = 0;
      repeat (24) begin
         @(posedge mclk);
         #1;
         if (latch_strobe === 1'b1) begin
            chk16("drained", 16'h1000 + 16'(k), latch_code);
            k++;
         end
      end
      chk16("drain_count", 16'h0008, 16'(k));
      chk1("word_ready", 1'b1, word_ready);
   endtask : t_buffer
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 10000) begin
         fail_count++;
         stop_test();
      end
   end
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      chk16("latch_code", 16'h0000, latch_code);
      chk1("receiving", 1'b0, receiving);
      chk16("string_tap", 16'h8000, string_tap);
      chk1("latch_strobe", 1'b0, latch_strobe);
      chk1("word_ready", 1'b1, word_ready);
      chk1("overrun", 1'b0, overrun);
      t_codes();
      t_frames();
      t_force();
      t_buffer();
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
